// *** shared/bdr_defines.svh ***
`ifndef BDR_DEFINES_SVH
`define BDR_DEFINES_SVH

// ----------------------------------------------------------------
// memory-mapped trace module offsets (byte index in the block)
// ----------------------------------------------------------------
`define BDR_OFS_CMP_A_HIGH 4'h0
`define BDR_OFS_CMP_A_LOW 4'h1
`define BDR_OFS_CMP_B_HIGH 4'h2
`define BDR_OFS_CMP_B_LOW 4'h3
`define BDR_OFS_FIFO_HIGH 4'h4
`define BDR_OFS_FIFO_LOW 4'h5
`define BDR_OFS_ARM_CTRL 4'h6
`define BDR_OFS_FORCE_RESET 4'h8

// ----------------------------------------------------------------
// debug_status_control bit positions
// ----------------------------------------------------------------
`define BDR_SC_BKGD_EN 7
`define BDR_SC_BKGD_ACT 6
`define BDR_SC_BKPT_EN 5
`define BDR_SC_FTS 4
`define BDR_SC_CLKSEL 3
`define BDR_SC_WS 2
`define BDR_SC_WSF 1
`define BDR_SC_DVF 0

// ----------------------------------------------------------------
// other field positions and reset values
// ----------------------------------------------------------------
`define BDR_ARM_BIT 0
`define BDR_FRST_BIT 0
`define BDR_CMP_RESET 8'h00
`define BDR_BKPT_RESET 16'h0000
`define BDR_READ_ZERO 8'h00

`endif

// *** shared/bdr_pkg.sv ***
`default_nettype none

package bdr_pkg;

  // serial command codes seen by the controller
  typedef enum logic [2:0] {
    BDR_CMD_READ_STATUS = 3'h0,
    BDR_CMD_WRITE_CONTROL = 3'h1,
    BDR_CMD_BREAKPOINT_READ = 3'h2,
    BDR_CMD_BREAKPOINT_WRITE = 3'h3,
    BDR_CMD_BACKGROUND = 3'h4,
    BDR_CMD_GO = 3'h5,
    BDR_CMD_MEM_ACCESS = 3'h6,
    BDR_CMD_NOP = 3'h7
  } bdr_cmd_e;

  // cpu run state, one-hot
  typedef enum logic [1:0] {
    BDR_RUN = 2'b01,
    BDR_BKGD = 2'b10
  } bdr_mode_e;

  typedef struct packed {
    bdr_mode_e mode;
    logic bkgd_en;
    logic bkpt_en;
    logic force_tag_select;
    logic clksel;
    logic ws_held;
    logic wait_stop_failure;
    logic [15:0] bkpt_addr;
    logic force_pend;
    logic tag_out;
    logic [7:0] cmp_a_high;
    logic [7:0] cmp_a_low;
    logic [7:0] cmp_b_high;
    logic [7:0] cmp_b_low;
    logic armed;
    logic [7:0] mem_rdata;
    logic fifo_adv;
    logic mcu_reset;
    logic [15:0] cmd_rdata;
    logic cmd_done;
  } bdr_state_s;

endpackage

`default_nettype wire

// *** hdl/bdr_top.sv ***
// Notes on behaviour
// - 8-bit status/control register, reachable only by serial commands, not memory mapped.
// - 16-bit breakpoint address, only serial breakpoint read/write commands reach it.
// - Writes to background enable are ignored while background mode is active.
// - Four status bits are read-only; write-control never alters them.
// - Background enable stays set until reset; while clear, no background entry.
// - Background-active reads 1 in background mode, 0 while user code runs.
// - Breakpoint enable clear disables breakpoint; select and address then ignored.
// - Force select: address match forces background at next instruction boundary.
// - Tag select: match tags opcode; background only if tagged opcode executes.
// - Clock select resets to 0 (alternate clock), 1 means bus clock; always writable.
// - Wait/stop status is 1 in wait/stop or after background command left it.
// - Background command accepted in wait/stop; other memory commands fail there.
// - Wait/stop failure set when a memory command collides with wait/stop.
// - Data-valid failure never reported; no slow-access memory exists.
// - Force-reset register written only by serial memory writes; reads zero.
// - Writing 1 to the force-reset bit serially produces a full MCU reset.
// - Trace module registers sit in the normal memory map for programs.
// - Comparator bytes reset to zero, always readable, writes blocked while armed.
// - FIFO high byte read-only, ignores writes, reads zero in event-only modes.
// - Reading the FIFO high byte does not advance the FIFO.
// - Reading the FIFO low byte advances the FIFO to the next word.
// - Armed bit set by a write, cleared automatically when the run completes unless the arm register is written in that cycle.

`timescale 1ns/10ps
`default_nettype none

`include "bdr_defines.svh"

module bdr_top (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // serial command channel from the link decoder
  input wire logic CMD_VALID,
  input wire bdr_pkg::bdr_cmd_e CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  output logic [15:0] CMD_RDATA,
  output logic CMD_DONE,
  // memory-mapped register access
  input wire logic MEM_SEL,
  input wire logic MEM_WR,
  input wire logic MEM_RD,
  input wire logic MEM_SERIAL,
  input wire logic [3:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic [7:0] MEM_RDATA,
  // cpu status and address bus
  input wire logic CPU_WAIT_STOP,
  input wire logic [15:0] CPU_ADDR,
  input wire logic CPU_ADDR_VALID,
  input wire logic CPU_OPCODE_FETCH,
  input wire logic CPU_INSTR_BOUNDARY,
  input wire logic CPU_TAG_EXEC,
  // trace module side
  input wire logic [15:0] FIFO_WORD,
  input wire logic EVENT_ONLY_MODE,
  input wire logic RUN_DONE,
  output logic FIFO_ADVANCE,
  output logic TRACE_ARMED,
  output logic [15:0] CMP_A_VALUE,
  output logic [15:0] CMP_B_VALUE,
  // controller outputs to the cpu and system
  output logic BKGD_ACTIVE,
  output logic OPCODE_TAG,
  output logic COMM_CLK_BUS,
  output logic MCU_RESET_REQ
);

  import bdr_pkg::*;

  bdr_state_s s_q;
  bdr_state_s s_d;

  // ----------------------------------------------------------------
  // combinational helpers
  // ----------------------------------------------------------------
  logic in_bkgd;
  logic cmd_take;
  logic bkpt_hit;
  logic mem_write;
  logic mem_read;
  logic enter_bkgd;
  logic [7:0] status_byte;
  logic cmd_bkgd;
  logic cmd_go;

  assign in_bkgd = (s_q.mode == BDR_BKGD);
  assign cmd_take = CMD_VALID;
  assign cmd_bkgd = cmd_take && (CMD_CODE == BDR_CMD_BACKGROUND);
  assign cmd_go = cmd_take && (CMD_CODE == BDR_CMD_GO);
  assign bkpt_hit = s_q.bkpt_en && CPU_ADDR_VALID && (CPU_ADDR == s_q.bkpt_addr);
  assign mem_write = MEM_SEL && MEM_WR;
  assign mem_read = MEM_SEL && MEM_RD;

  // ----------------------------------------------------------------
  // register select
  // ----------------------------------------------------------------
  // one decode shared by the write and read paths, so the two can
  // never disagree about which byte an offset names
  logic sel_cmp_a_high;
  logic sel_cmp_a_low;
  logic sel_cmp_b_high;
  logic sel_cmp_b_low;
  logic sel_fifo_high;
  logic sel_fifo_low;
  logic sel_arm;
  logic sel_force_reset;

  always_comb begin
    sel_cmp_a_high = 1'b0;
    sel_cmp_a_low = 1'b0;
    sel_cmp_b_high = 1'b0;
    sel_cmp_b_low = 1'b0;
    sel_fifo_high = 1'b0;
    sel_fifo_low = 1'b0;
    sel_arm = 1'b0;
    sel_force_reset = 1'b0;
    if (MEM_ADDR == `BDR_OFS_CMP_A_HIGH) begin
      sel_cmp_a_high = 1'b1;
    end else if (MEM_ADDR == `BDR_OFS_CMP_A_LOW) begin
      sel_cmp_a_low = 1'b1;
    end else if (MEM_ADDR == `BDR_OFS_CMP_B_HIGH) begin
      sel_cmp_b_high = 1'b1;
    end else if (MEM_ADDR == `BDR_OFS_CMP_B_LOW) begin
      sel_cmp_b_low = 1'b1;
    end else if (MEM_ADDR == `BDR_OFS_FIFO_HIGH) begin
      sel_fifo_high = 1'b1;
    end else if (MEM_ADDR == `BDR_OFS_FIFO_LOW) begin
      sel_fifo_low = 1'b1;
    end else if (MEM_ADDR == `BDR_OFS_ARM_CTRL) begin
      sel_arm = 1'b1;
    end else if (MEM_ADDR == `BDR_OFS_FORCE_RESET) begin
      sel_force_reset = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // status byte as the host sees it
  // ----------------------------------------------------------------
  always_comb begin
    status_byte = 8'h00;
    status_byte[`BDR_SC_BKGD_EN] = s_q.bkgd_en;
    status_byte[`BDR_SC_BKGD_ACT] = in_bkgd;
    status_byte[`BDR_SC_BKPT_EN] = s_q.bkpt_en;
    status_byte[`BDR_SC_FTS] = s_q.force_tag_select;
    status_byte[`BDR_SC_CLKSEL] = s_q.clksel;
    status_byte[`BDR_SC_WS] = CPU_WAIT_STOP || s_q.ws_held;
    status_byte[`BDR_SC_WSF] = s_q.wait_stop_failure;
    status_byte[`BDR_SC_DVF] = 1'b0;
  end

  // ----------------------------------------------------------------
  // background entry decision
  // ----------------------------------------------------------------
  // entry is gated by the enable bit; without it, breakpoints and the
  // background command are dropped here and the cpu keeps running
  always_comb begin
    enter_bkgd = 1'b0;
    if (s_q.bkgd_en && !in_bkgd) begin
      if (s_q.force_pend && CPU_INSTR_BOUNDARY) begin
        enter_bkgd = 1'b1;
      end else if (CPU_TAG_EXEC) begin
        enter_bkgd = 1'b1;
      end else if (cmd_bkgd) begin
        enter_bkgd = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.cmd_done = 1'b0;
    s_d.fifo_adv = 1'b0;
    s_d.mcu_reset = 1'b0;
    s_d.tag_out = 1'b0;

    // ----------------------------------------------------------------
    // run state machine
    // ----------------------------------------------------------------
    case (s_q.mode)
      BDR_RUN: begin
        if (enter_bkgd) begin
          s_d.mode = BDR_BKGD;
          // remember that the cpu was parked in wait or stop
          s_d.ws_held = CPU_WAIT_STOP;
        end
      end
      BDR_BKGD: begin
        if (cmd_go) begin
          s_d.mode = BDR_RUN;
          s_d.ws_held = 1'b0;
        end
      end
      default: begin
        s_d.mode = BDR_RUN;
      end
    endcase

    // ----------------------------------------------------------------
    // breakpoint matching
    // ----------------------------------------------------------------
    // a force request waits for the boundary; a new match while one
    // is already pending merges with it
    if (!s_q.bkpt_en) begin
      s_d.force_pend = 1'b0;
    end else if (enter_bkgd) begin
      s_d.force_pend = 1'b0;
    end else if (s_q.force_pend && CPU_INSTR_BOUNDARY) begin
      // a request refused for want of the enable is spent at its
      // boundary, so a later enable cannot fire a stale break
      s_d.force_pend = 1'b0;
    end else if (bkpt_hit && s_q.force_tag_select && !in_bkgd) begin
      s_d.force_pend = 1'b1;
    end
    if (bkpt_hit && !s_q.force_tag_select && CPU_OPCODE_FETCH && !in_bkgd) begin
      s_d.tag_out = 1'b1;
    end

    // ----------------------------------------------------------------
    // serial commands
    // ----------------------------------------------------------------
    if (cmd_take) begin
      s_d.cmd_done = 1'b1;
      s_d.cmd_rdata = 16'h0000;
      case (CMD_CODE)
        BDR_CMD_READ_STATUS: begin
          s_d.cmd_rdata = {8'h00, status_byte};
        end
        BDR_CMD_WRITE_CONTROL: begin
          // enable is sticky, and frozen while background is active
          if (!in_bkgd && CMD_WDATA[`BDR_SC_BKGD_EN]) begin
            s_d.bkgd_en = 1'b1;
          end
          s_d.bkpt_en = CMD_WDATA[`BDR_SC_BKPT_EN];
          s_d.force_tag_select = CMD_WDATA[`BDR_SC_FTS];
          s_d.clksel = CMD_WDATA[`BDR_SC_CLKSEL];
          // status bits are not taken from the write data
        end
        BDR_CMD_BREAKPOINT_READ: begin
          s_d.cmd_rdata = s_q.bkpt_addr;
        end
        BDR_CMD_BREAKPOINT_WRITE: begin
          s_d.bkpt_addr = CMD_WDATA;
        end
        BDR_CMD_MEM_ACCESS: begin
          // a memory command cannot complete while the cpu sleeps
          if (CPU_WAIT_STOP) begin
            s_d.wait_stop_failure = 1'b1;
          end else begin
            s_d.wait_stop_failure = 1'b0;
          end
        end
        default: begin
          s_d.cmd_rdata = 16'h0000;
        end
      endcase
    end

    // ----------------------------------------------------------------
    // memory-mapped registers
    // ----------------------------------------------------------------
    if (mem_write) begin
      if (sel_cmp_a_high) begin
        if (!s_q.armed) begin
          s_d.cmp_a_high = MEM_WDATA;
        end
      end else if (sel_cmp_a_low) begin
        if (!s_q.armed) begin
          s_d.cmp_a_low = MEM_WDATA;
        end
      end else if (sel_cmp_b_high) begin
        if (!s_q.armed) begin
          s_d.cmp_b_high = MEM_WDATA;
        end
      end else if (sel_cmp_b_low) begin
        if (!s_q.armed) begin
          s_d.cmp_b_low = MEM_WDATA;
        end
      end else if (sel_arm) begin
        s_d.armed = MEM_WDATA[`BDR_ARM_BIT];
      end else if (sel_force_reset) begin
        // program writes are dropped; only the serial path may reset
        if (MEM_SERIAL && MEM_WDATA[`BDR_FRST_BIT]) begin
          s_d.mcu_reset = 1'b1;
        end
      end
      // fifo bytes ignore writes
    end

    // run completion clears the arm bit unless software arms again
    // in the same cycle, so a fresh arm is never lost
    if (RUN_DONE && !(mem_write && sel_arm)) begin
      s_d.armed = 1'b0;
    end

    if (mem_read) begin
      if (sel_cmp_a_high) begin
        s_d.mem_rdata = s_q.cmp_a_high;
      end else if (sel_cmp_a_low) begin
        s_d.mem_rdata = s_q.cmp_a_low;
      end else if (sel_cmp_b_high) begin
        s_d.mem_rdata = s_q.cmp_b_high;
      end else if (sel_cmp_b_low) begin
        s_d.mem_rdata = s_q.cmp_b_low;
      end else if (sel_fifo_high) begin
        // high byte is unused when only data bytes are traced
        if (EVENT_ONLY_MODE) begin
          s_d.mem_rdata = `BDR_READ_ZERO;
        end else begin
          s_d.mem_rdata = FIFO_WORD[15:8];
        end
      end else if (sel_fifo_low) begin
        s_d.mem_rdata = FIFO_WORD[7:0];
        s_d.fifo_adv = 1'b1;
      end else if (sel_arm) begin
        s_d.mem_rdata = {7'h00, s_q.armed};
      end else if (sel_force_reset) begin
        s_d.mem_rdata = `BDR_READ_ZERO;
      end else begin
        s_d.mem_rdata = `BDR_READ_ZERO;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      s_q.mode <= BDR_RUN;
      s_q.bkgd_en <= 1'b0;
      s_q.bkpt_en <= 1'b0;
      s_q.force_tag_select <= 1'b0;
      s_q.clksel <= 1'b0;
      s_q.ws_held <= 1'b0;
      s_q.wait_stop_failure <= 1'b0;
      s_q.bkpt_addr <= `BDR_BKPT_RESET;
      s_q.force_pend <= 1'b0;
      s_q.tag_out <= 1'b0;
      s_q.cmp_a_high <= `BDR_CMP_RESET;
      s_q.cmp_a_low <= `BDR_CMP_RESET;
      s_q.cmp_b_high <= `BDR_CMP_RESET;
      s_q.cmp_b_low <= `BDR_CMP_RESET;
      s_q.armed <= 1'b0;
      s_q.mem_rdata <= 8'h00;
      s_q.fifo_adv <= 1'b0;
      s_q.mcu_reset <= 1'b0;
      s_q.cmd_rdata <= 16'h0000;
      s_q.cmd_done <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from the state register
  // ----------------------------------------------------------------
  assign CMD_RDATA = s_q.cmd_rdata;
  assign CMD_DONE = s_q.cmd_done;
  assign MEM_RDATA = s_q.mem_rdata;
  assign FIFO_ADVANCE = s_q.fifo_adv;
  assign TRACE_ARMED = s_q.armed;
  assign CMP_A_VALUE = {s_q.cmp_a_high, s_q.cmp_a_low};
  assign CMP_B_VALUE = {s_q.cmp_b_high, s_q.cmp_b_low};
  assign BKGD_ACTIVE = s_q.mode[1]; // one-hot background flop itself
  assign OPCODE_TAG = s_q.tag_out;
  assign COMM_CLK_BUS = s_q.clksel;
  assign MCU_RESET_REQ = s_q.mcu_reset;

endmodule

`default_nettype wire

// *** tb/bdr_checker_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module bdr_checker (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // serial commands
  input wire logic CMD_VALID,
  input wire bdr_pkg::bdr_cmd_e CMD_CODE,
  input wire logic [15:0] CMD_WDATA,
  input wire logic [15:0] CMD_RDATA,
  input wire logic CMD_DONE,
  // memory access
  input wire logic MEM_SEL,
  input wire logic MEM_WR,
  input wire logic MEM_RD,
  input wire logic MEM_SERIAL,
  input wire logic [3:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  // trace and controller outputs
  input wire logic [15:0] FIFO_WORD,
  input wire logic EVENT_ONLY_MODE,
  input wire logic RUN_DONE,
  input wire logic FIFO_ADVANCE,
  input wire logic TRACE_ARMED,
  input wire logic [15:0] CMP_A_VALUE,
  input wire logic [15:0] CMP_B_VALUE,
  input wire logic BKGD_ACTIVE,
  input wire logic COMM_CLK_BUS,
  input wire logic MCU_RESET_REQ
);
  import bdr_pkg::*;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  // ----------------------------------------------------------------
  // decoded accesses
  // ----------------------------------------------------------------
  wire rd_hi = MEM_SEL && MEM_RD && MEM_ADDR == 4'h4;
  wire rd_lo = MEM_SEL && MEM_RD && MEM_ADDR == 4'h5;
  wire wr_frst = MEM_SEL && MEM_WR && MEM_ADDR == 4'h8 && MEM_WDATA[0];
  wire wr_arm = MEM_SEL && MEM_WR && MEM_ADDR == 4'h6;
  wire [7:0] fifo_hi = EVENT_ONLY_MODE ? 8'h00 : FIFO_WORD[15:8];
  wire clk_req = CMD_WDATA[3];
  // a status answer is the done pulse that follows a status command
  logic stat_q;
  always_ff @(posedge CLOCK) begin
    stat_q <= CMD_VALID && (CMD_CODE == BDR_CMD_READ_STATUS);
  end
  wire rd_stat = CMD_DONE && stat_q;
  dvf_zero_a: assert property (rd_stat |-> !CMD_RDATA[0])
    else $error("slow-access failure reported");
  active_status_a: assert property (rd_stat |-> CMD_RDATA[6] == $past(BKGD_ACTIVE))
    else $error("status active bit wrong");
  clk_select_a: assert property (CMD_VALID && CMD_CODE == BDR_CMD_WRITE_CONTROL
    |=> COMM_CLK_BUS == $past(clk_req))
    else $error("clock select not written");
  go_exit_a: assert property (CMD_VALID && CMD_CODE == BDR_CMD_GO |=> !BKGD_ACTIVE)
    else $error("background kept after go");
  fifo_adv_a: assert property (rd_lo |=> FIFO_ADVANCE)
    else $error("low read did not advance");
  fifo_hold_a: assert property (rd_hi |=> !FIFO_ADVANCE)
    else $error("high read advanced fifo");
  fifo_high_a: assert property (rd_hi |=> MEM_RDATA == $past(fifo_hi))
    else $error("fifo high byte wrong");
  serial_rst_a: assert property (wr_frst && MEM_SERIAL |=> MCU_RESET_REQ)
    else $error("forced reset missing");
  user_rst_a: assert property (wr_frst && !MEM_SERIAL |=> !MCU_RESET_REQ)
    else $error("user write forced reset");
  cmp_lock_a: assert property (TRACE_ARMED |=> $stable(CMP_A_VALUE) && $stable(CMP_B_VALUE))
    else $error("comparator changed while armed");
  arm_clear_a: assert property (RUN_DONE && !wr_arm |=> !TRACE_ARMED)
    else $error("armed not cleared at run end");
  done_pulse_a: assert property (CMD_DONE == $past(CMD_VALID))
    else $error("command done pulse misplaced");
endmodule
bind bdr_top bdr_checker bdr_checker_inst (.*);
`default_nettype wire

// *** tb/bdr_host_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module bdr_host_model (
  // clock
  input wire logic clock,
  // command channel
  output logic cmd_valid,
  output bdr_pkg::bdr_cmd_e cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] cmd_rdata
);
  import bdr_pkg::*;
  initial begin
    cmd_valid = 1'b0;
    cmd_code = BDR_CMD_NOP;
    cmd_wdata = 16'h0000;
  end
  // data is inverted once released so a stale value never looks valid
  task send(input bdr_cmd_e c, input logic [15:0] d, output logic [15:0] r);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    cmd_wdata <= d;
    @(posedge clock);
    cmd_valid <= 1'b0;
    cmd_wdata <= ~d;
    #1;
    r = cmd_rdata;
  endtask
  // background entry is always confirmed by a status read
  task enter_bg(output logic [15:0] st);
    logic [15:0] r;
    send(BDR_CMD_BACKGROUND, 16'h0000, r);
    send(BDR_CMD_READ_STATUS, 16'h0000, st);
  endtask
endmodule
`default_nettype wire

// *** tb/bdr_top_tb.sv ***
`timescale 1ns/10ps
`default_nettype none
module bdr_top_tb;
  import bdr_pkg::*;
  logic CLOCK = 1'b0, SYS_RST = 1'b1, MEM_SEL = 1'b0, MEM_WR = 1'b0, MEM_RD = 1'b0;
  logic MEM_SERIAL = 1'b0, CPU_WAIT_STOP = 1'b0, CPU_ADDR_VALID = 1'b0, CPU_OPCODE_FETCH = 1'b0;
  logic CPU_INSTR_BOUNDARY = 1'b0, CPU_TAG_EXEC = 1'b0, EVENT_ONLY_MODE = 1'b0, RUN_DONE = 1'b0;
  logic [3:0] MEM_ADDR = 4'h0;
  logic [7:0] MEM_WDATA = 8'h00, MEM_RDATA;
  logic [15:0] CPU_ADDR = 16'h0000, FIFO_WORD = 16'h0000, CMD_WDATA, CMD_RDATA, r;
  logic [15:0] CMP_A_VALUE, CMP_B_VALUE;
  logic CMD_VALID, CMD_DONE, FIFO_ADVANCE, TRACE_ARMED, BKGD_ACTIVE, OPCODE_TAG, tg;
  logic COMM_CLK_BUS, MCU_RESET_REQ;
  bdr_cmd_e CMD_CODE;
  int n_errors = 0, comparisons = 0;
  always #25 CLOCK = ~CLOCK;
  bdr_top bdr_top_inst (.*);
  bdr_host_model bdr_host_model_inst (.clock(CLOCK), .cmd_valid(CMD_VALID),
    .cmd_code(CMD_CODE), .cmd_wdata(CMD_WDATA), .cmd_rdata(CMD_RDATA));
  // ----------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------
  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task cmd(input bdr_cmd_e c, input logic [15:0] d);
    bdr_host_model_inst.send(c, d, r);
  endtask
  task stat(input logic [7:0] e);
    cmd(BDR_CMD_READ_STATUS, 16'h0000);
    chk(r, {8'h00, e});
  endtask
  task rst;
    @(posedge CLOCK);
    SYS_RST <= 1'b1;
    repeat (6) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    #1;
  endtask
  // bounded wait, the entry latency differs per path
  task bg(input logic e);
    repeat (4) if (BKGD_ACTIVE !== e) @(posedge CLOCK);
    #1;
    chk(BKGD_ACTIVE, e);
  endtask
  task mem(input logic w, input logic s, input logic [3:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    MEM_SEL <= 1'b1;
    MEM_WR <= w;
    MEM_RD <= !w;
    MEM_SERIAL <= s;
    MEM_ADDR <= a;
    MEM_WDATA <= d;
    @(posedge CLOCK);
    MEM_SEL <= 1'b0;
    MEM_WR <= 1'b0;
    MEM_RD <= 1'b0;
    MEM_WDATA <= ~d;
    #1;
  endtask
  // match cycle, then an instruction boundary; tag pulse captured between
  task fetch(input logic [15:0] a);
    @(posedge CLOCK);
    CPU_ADDR <= a;
    CPU_ADDR_VALID <= 1'b1;
    CPU_OPCODE_FETCH <= 1'b1;
    @(posedge CLOCK);
    CPU_ADDR_VALID <= 1'b0;
    CPU_OPCODE_FETCH <= 1'b0;
    CPU_INSTR_BOUNDARY <= 1'b1;
    #1;
    tg = OPCODE_TAG;
    @(posedge CLOCK);
    CPU_INSTR_BOUNDARY <= 1'b0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk(CMP_A_VALUE, 16'h0000);
    chk(CMP_B_VALUE, 16'h0000);
    chk(COMM_CLK_BUS, 1'b0);
    stat(8'h00);
    cmd(BDR_CMD_BACKGROUND, 16'h0000);
    bg(1'b0);
  endtask
  task t_ctrl;
    cmd(BDR_CMD_WRITE_CONTROL, 16'h00ff);
    stat(8'hb8);
    chk(COMM_CLK_BUS, 1'b1);
    cmd(BDR_CMD_WRITE_CONTROL, 16'h0000);
    stat(8'h80);
  endtask
  task t_bkgd;
    bdr_host_model_inst.enter_bg(r);
    chk(r, 16'h00c0);
    cmd(BDR_CMD_WRITE_CONTROL, 16'h0000);
    stat(8'hc0);
    cmd(BDR_CMD_BREAKPOINT_WRITE, 16'ha5c3);
    cmd(BDR_CMD_BREAKPOINT_READ, 16'h0000);
    chk(r, 16'ha5c3);
    cmd(BDR_CMD_BREAKPOINT_WRITE, 16'h1234);
    cmd(BDR_CMD_GO, 16'h0000);
    bg(1'b0);
  endtask
  task t_break;
    cmd(BDR_CMD_WRITE_CONTROL, 16'h00b0);
    fetch(16'h1234);
    bg(1'b1);
    cmd(BDR_CMD_GO, 16'h0000);
    cmd(BDR_CMD_WRITE_CONTROL, 16'h00a0);
    fetch(16'h1234);
    chk(tg, 1'b1);
    bg(1'b0);
    @(posedge CLOCK);
    CPU_TAG_EXEC <= 1'b1;
    @(posedge CLOCK);
    CPU_TAG_EXEC <= 1'b0;
    bg(1'b1);
    cmd(BDR_CMD_GO, 16'h0000);
    cmd(BDR_CMD_WRITE_CONTROL, 16'h0090);
    fetch(16'h1234);
    chk(tg, 1'b0);
    bg(1'b0);
  endtask
  task t_wait;
    @(posedge CLOCK);
    CPU_WAIT_STOP <= 1'b1;
    stat(8'h94);
    cmd(BDR_CMD_MEM_ACCESS, 16'h0000);
    stat(8'h96);
    bdr_host_model_inst.enter_bg(r);
    chk(r, 16'h00d6);
    @(posedge CLOCK);
    CPU_WAIT_STOP <= 1'b0;
    cmd(BDR_CMD_MEM_ACCESS, 16'h0000);
    stat(8'hd4);
    cmd(BDR_CMD_GO, 16'h0000);
    stat(8'h90);
  endtask
  task t_mem;
    mem(1'b1, 1'b0, 4'h0, 8'h12);
    mem(1'b1, 1'b0, 4'h1, 8'h34);
    mem(1'b1, 1'b0, 4'h2, 8'hab);
    mem(1'b1, 1'b0, 4'h3, 8'hcd);
    chk(CMP_A_VALUE, 16'h1234);
    chk(CMP_B_VALUE, 16'habcd);
    mem(1'b0, 1'b0, 4'h1, 8'h00);
    chk(MEM_RDATA, 8'h34);
    mem(1'b1, 1'b0, 4'h6, 8'h01);
    chk(TRACE_ARMED, 1'b1);
    mem(1'b1, 1'b0, 4'h0, 8'hff);
    chk(CMP_A_VALUE, 16'h1234);
    @(posedge CLOCK);
    RUN_DONE <= 1'b1;
    FIFO_WORD <= 16'h5a6b;
    @(posedge CLOCK);
    RUN_DONE <= 1'b0;
    #1;
    chk(TRACE_ARMED, 1'b0);
    mem(1'b1, 1'b0, 4'h4, 8'hff);
    mem(1'b0, 1'b0, 4'h4, 8'h00);
    chk(MEM_RDATA, 8'h5a);
    chk(FIFO_ADVANCE, 1'b0);
    mem(1'b0, 1'b0, 4'h5, 8'h00);
    chk(FIFO_ADVANCE, 1'b1);
    chk(MEM_RDATA, 8'h6b);
    @(posedge CLOCK);
    EVENT_ONLY_MODE <= 1'b1;
    mem(1'b0, 1'b0, 4'h4, 8'h00);
    chk(MEM_RDATA, 8'h00);
    mem(1'b1, 1'b0, 4'h8, 8'h01);
    chk(MCU_RESET_REQ, 1'b0);
    mem(1'b0, 1'b1, 4'h8, 8'h00);
    chk(MEM_RDATA, 8'h00);
    mem(1'b1, 1'b1, 4'h8, 8'h01);
    chk(MCU_RESET_REQ, 1'b1);
  endtask
  task summarize;
    if (n_errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
  initial begin
    rst;
    t_reset;
    t_ctrl;
    t_bkgd;
    t_break;
    t_wait;
    t_mem;
    rst;
    t_reset;
    summarize;
  end
endmodule
`default_nettype wire
